// *** hw/gpio_pkg.sv ***
// constants, register indices and mode codes for the i/o port block
package gpio_pkg;
  localparam int ADDR_W = 12;               // apb byte address width
  localparam int NUM_LANES = 6;             // bidirectional ports handled by lanes
  localparam int LANE_P0 = 0;               // port_zero
  localparam int LANE_P1 = 1;               // port_one
  localparam int LANE_P2 = 2;               // port_two
  localparam int LANE_P3 = 3;               // port_three
  localparam int LANE_P4 = 4;               // port_four
  localparam int LANE_P6 = 5;               // port_six
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_P0_DATA = 8'hc0;
  localparam logic [7:0] IDX_P0_DIR = 8'hc1;
  localparam logic [7:0] IDX_LANE_LAST = 8'hcb;
  localparam logic [7:0] IDX_COLOUR = 8'hcc;
  localparam logic [7:0] IDX_OSC = 8'hcd;
  localparam logic [7:0] IDX_ALT = 8'hce;
  localparam logic [7:0] IDX_PWM_EN = 8'hcf;
  localparam logic [7:0] IDX_MODE = 8'hfb;
  // alternate function select bits
  localparam int ALT_SER1 = 0;
  localparam int ALT_SER2 = 1;
  localparam int ALT_SPECIAL = 2;
  localparam int ALT_PULSE_WIDTH_CHANNEL_NINE = 3;
  localparam int ALT_PWM8 = 4;
  localparam int ALT_TMR2 = 5;
  localparam int ALT_TMR3 = 6;
  localparam int ALT_COLOUR = 7;
  localparam logic [7:0] PORT3_USED = 8'h7f;  // port_three has seven pins
  localparam logic [7:0] OD_P3 = 8'h7c;       // port_three open-drain bits
  localparam logic [7:0] OD_ALL = 8'hff;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] STRAP_WAIT = 2'd3;   // cycles before strap capture
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_EXPANSION = 2'b01,
    MODE_MICRO = 2'b10,
    MODE_SPARE = 2'b11
  } mode_type;
endpackage : gpio_pkg

// *** hw/port_lane_if.sv ***
// control and status carried between the port block and one pin lane
`timescale 1ns/100ps
`default_nettype none
interface port_lane_if #(parameter int W = 8);
  logic [W-1:0] latch;      // port latch
  logic [W-1:0] dir;        // 1 = output
  logic [W-1:0] own_en;     // alternate function owns the bit
  logic [W-1:0] own_val;    // alternate function value
  logic [W-1:0] own_drive;  // alternate function wants to drive
  logic [W-1:0] od_mask;    // 1 = open-drain bit
  logic [W-1:0] level;      // synchronised pin level
  modport ctrl (output latch, dir, own_en, own_val, own_drive, od_mask, input level);
  modport lane (input latch, dir, own_en, own_val, own_drive, od_mask, output level);
endinterface : port_lane_if
`default_nettype wire

// *** hw/port_lane.sv ***
// one port worth of pin drivers and input synchronisers
`timescale 1ns/100ps
`default_nettype none
module port_lane #(parameter int W = 8) (
  input wire logic pclk,
  input wire logic presetn,
  port_lane_if.lane lane,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_n
);
  logic [W-1:0] meta_reg;   // first sync stage, read only by the second
  logic [W-1:0] level_reg;  // second sync stage
  logic [W-1:0] drive_next;
  logic [W-1:0] val_next;

  // the owner of the bit decides; latch and dir stay untouched
  always_comb begin
    drive_next = (lane.own_en & lane.own_drive) | (~lane.own_en & lane.dir);
    val_next = (lane.own_en & lane.own_val) | (~lane.own_en & lane.latch);
  end

  // pin drivers; open-drain bits only ever pull low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out <= val_next & ~lane.od_mask;
      pin_oe_n <= ~(drive_next & (~lane.od_mask | ~val_next));
    end
  end

  // two-stage synchroniser for the pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      level_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      level_reg <= meta_reg;
    end
  end
  assign lane.level = level_reg;

  a_input_float: assert property (@(posedge pclk) disable iff (!presetn)
    (lane.own_en == '0 && lane.dir == '0) |=> pin_oe_n == '1)
    else $error("input bit driven");
  a_latch_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (lane.own_en == '0 && lane.dir == '1 && lane.od_mask == '0)
      |=> (pin_out == $past(lane.latch) && pin_oe_n == '0))
    else $error("output pin differs from latch");
endmodule : port_lane
`default_nettype wire

// *** hw/io_ports.sv ***
// i/o ports with direction registers, alternate functions and bus modes
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module io_ports
  import gpio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_LANES-1:0][7:0] gpio_pin_in,
  output logic [NUM_LANES-1:0][7:0] gpio_pin_out,
  output logic [NUM_LANES-1:0][7:0] gpio_pin_oe_n,
  output logic [NUM_LANES-1:0][7:0] gpio_pin_level,
  input wire logic [15:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  input wire logic ext_write,
  input wire logic ext_sync,
  input wire logic [3:0] serial_one_val,
  input wire logic [3:0] serial_one_drive,
  input wire logic [3:0] serial_two_val,
  input wire logic [3:0] serial_two_drive,
  input wire logic special_sda_val,
  input wire logic special_scl_val,
  input wire logic [7:0] pulse_width_channels_low,
  input wire logic pulse_width_channel_eight,
  input wire logic pulse_width_channel_nine,
  input wire logic [4:0] display_colour,
  output logic [4:0] colour_output_port,
  input wire logic display_osc_in,
  input wire logic display_osc_out,
  input wire logic mode_select_pin,
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic clock_resume,
  output logic system_clock_out,
  output logic [1:0] timer_ext_clk,
  output logic rom_disable
);
  logic [NUM_LANES-1:0][7:0] data_reg;  // port latches
  logic [NUM_LANES-1:0][7:0] dir_reg;   // direction bits
  logic [NUM_LANES-1:0][7:0] own_en;
  logic [NUM_LANES-1:0][7:0] own_val;
  logic [NUM_LANES-1:0][7:0] own_drive;
  logic [NUM_LANES-1:0][7:0] od_mask;
  logic [NUM_LANES-1:0][7:0] level;
  logic [4:0] colour_data_reg;          // output-only port latch
  logic [7:0] alt_reg;                  // alternate function selects
  logic [7:0] pwm_en_reg;               // port_six pwm owners
  mode_type mode_reg;
  logic [1:0] strap_cnt_reg;            // counts to strap capture
  logic mode_meta_reg;
  logic mode_sync_reg;
  logic [1:0] osc_meta_reg;
  logic [1:0] osc_level_reg;
  logic halt_reg;                       // clock output parked high
  logic bus_mode;
  logic [7:0] idx;
  logic addr_ok;
  logic [7:0] rd_val;
  logic wr_fire;

  // register index is the word address; upper bits must be zero
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
  assign wr_fire = psel && penable && pwrite && pready;
  assign bus_mode = (mode_reg != MODE_SINGLE);

  // true when the index is one of the lane data or direction registers
  function automatic logic is_lane_reg(input logic [7:0] i);
    is_lane_reg = (i >= IDX_P0_DATA) && (i <= IDX_LANE_LAST);
  endfunction : is_lane_reg

  // lane number behind a lane register index
  function automatic int lane_of(input logic [7:0] i);
    logic [7:0] off;
    off = i - IDX_P0_DATA;
    lane_of = int'(off[7:1]);
  endfunction : lane_of

  // any index that answers without error
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = is_lane_reg(i) || (i >= IDX_COLOUR && i <= IDX_PWM_EN) || (i == IDX_MODE);
  endfunction : is_mapped

  // lane latches and direction bits; writes never touch the pins directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= '0;
      dir_reg <= '0;
    end else if (wr_fire && addr_ok && is_lane_reg(idx)) begin
      if (idx[0]) begin
        dir_reg[lane_of(idx)] <= pwdata[7:0];
      end else begin
        data_reg[lane_of(idx)] <= pwdata[7:0];
      end
    end
  end

  // alternate function selects and the output-only latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      colour_data_reg <= '0;
      alt_reg <= REG_RESET;
      pwm_en_reg <= REG_RESET;
    end else if (wr_fire && addr_ok) begin
      if (idx == IDX_COLOUR) begin
        colour_data_reg <= pwdata[6:2];
      end
      if (idx == IDX_ALT) begin
        alt_reg <= pwdata[7:0];
      end
      if (idx == IDX_PWM_EN) begin
        pwm_en_reg <= pwdata[7:0];
      end
    end
  end

  // strap synchroniser; the strap is sampled only after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
    end else begin
      mode_meta_reg <= mode_select_pin;
      mode_sync_reg <= mode_meta_reg;
    end
  end

  // mode bits: reset to single-chip, strap high forces expansion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_SINGLE;
      strap_cnt_reg <= '0;
    end else if (strap_cnt_reg != STRAP_WAIT) begin
      strap_cnt_reg <= strap_cnt_reg + 2'd1;
      if (strap_cnt_reg == STRAP_WAIT - 2'd1 && mode_sync_reg) begin
        mode_reg <= MODE_EXPANSION;
      end
    end else if (wr_fire && addr_ok && idx == IDX_MODE) begin
      mode_reg <= mode_type'(pwdata[1:0]);
    end
  end

  // internal rom is cut off only in microprocessor mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_disable <= 1'b0;
    end else begin
      rom_disable <= (mode_reg == MODE_MICRO);
    end
  end

  // decide who owns each pin; bus modes take priority over latches
  always_comb begin
    own_en = '0;
    own_val = '0;
    own_drive = '0;
    od_mask = '0;
    od_mask[LANE_P3] = OD_P3;
    od_mask[LANE_P4] = OD_ALL;
    od_mask[LANE_P6] = OD_ALL;
    // the missing eighth pin of port_three stays released
    own_en[LANE_P3][7] = 1'b1;
    if (bus_mode) begin
      own_en[LANE_P0] = 8'hff;
      own_val[LANE_P0] = ext_addr[7:0];
      own_drive[LANE_P0] = 8'hff;
      own_en[LANE_P1] = 8'hff;
      own_val[LANE_P1] = ext_addr[15:8];
      own_drive[LANE_P1] = 8'hff;
      own_en[LANE_P2] = 8'hff;
      own_val[LANE_P2] = ext_wdata;
      own_drive[LANE_P2] = {8{ext_write}};
      own_en[LANE_P3][1:0] = 2'b11;
      own_val[LANE_P3][1:0] = {ext_sync, ~ext_write};
      own_drive[LANE_P3][1:0] = 2'b11;
    end
    if (alt_reg[ALT_SER1]) begin
      own_en[LANE_P4][3:0] = 4'hf;
      own_val[LANE_P4][3:0] = serial_one_val;
      own_drive[LANE_P4][3:0] = serial_one_drive;
    end
    if (alt_reg[ALT_SER2]) begin
      own_en[LANE_P4][7:4] = 4'hf;
      own_val[LANE_P4][7:4] = serial_two_val;
      own_drive[LANE_P4][7:4] = serial_two_drive;
    end
    // special serial mode: bit 4 data line, bit 5 clock line
    if (alt_reg[ALT_SPECIAL]) begin
      own_en[LANE_P4][5:4] = 2'b11;
      own_val[LANE_P4][5:4] = {special_scl_val, special_sda_val};
      own_drive[LANE_P4][5:4] = 2'b11;
    end
    // pwm outputs win over the second serial channel on bits 6 and 7
    if (alt_reg[ALT_PULSE_WIDTH_CHANNEL_NINE]) begin
      own_en[LANE_P4][6] = 1'b1;
      own_val[LANE_P4][6] = pulse_width_channel_nine;
      own_drive[LANE_P4][6] = 1'b1;
    end
    if (alt_reg[ALT_PWM8]) begin
      own_en[LANE_P4][7] = 1'b1;
      own_val[LANE_P4][7] = pulse_width_channel_eight;
      own_drive[LANE_P4][7] = 1'b1;
    end
    own_en[LANE_P6] = pwm_en_reg;
    own_val[LANE_P6] = pulse_width_channels_low;
    own_drive[LANE_P6] = 8'hff;
  end

  // one lane per bidirectional port
  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
    port_lane_if #(.W(8)) lif ();
    assign lif.latch = data_reg[i];
    assign lif.dir = (i == LANE_P3) ? (dir_reg[i] & PORT3_USED) : dir_reg[i];
    assign lif.own_en = own_en[i];
    assign lif.own_val = own_val[i];
    assign lif.own_drive = own_drive[i];
    assign lif.od_mask = od_mask[i];
    assign level[i] = lif.level;
    assign gpio_pin_level[i] = lif.level;
    port_lane #(.W(8)) u_lane (
      .pclk(pclk),
      .presetn(presetn),
      .lane(lif),
      .pin_in(gpio_pin_in[i]),
      .pin_out(gpio_pin_out[i]),
      .pin_oe_n(gpio_pin_oe_n[i])
    );
  end

  // timer external clocks from port_three bits 2 and 3 when selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ext_clk <= '0;
    end else begin
      timer_ext_clk[0] <= alt_reg[ALT_TMR2] & level[LANE_P3][2];
      timer_ext_clk[1] <= alt_reg[ALT_TMR3] & level[LANE_P3][3];
    end
  end

  // colour pins: display outputs or the output-only latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      colour_output_port <= '0;
    end else begin
      colour_output_port <= alt_reg[ALT_COLOUR] ? display_colour : colour_data_reg;
    end
  end

  // oscillator pins sampled as an input-only port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_meta_reg <= '0;
      osc_level_reg <= '0;
    end else begin
      osc_meta_reg <= {display_osc_out, display_osc_in};
      osc_level_reg <= osc_meta_reg;
    end
  end

  // clock output at half rate; a halt parks it high until resume
  // a halt request in the same cycle as resume keeps the clock parked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_reg <= 1'b0;
      system_clock_out <= 1'b0;
    end else begin
      if (stop_instruction || wait_instruction) begin
        halt_reg <= 1'b1;
        system_clock_out <= 1'b1;
      end else if (clock_resume) begin
        halt_reg <= 1'b0;
        system_clock_out <= ~system_clock_out;
      end else if (halt_reg) begin
        system_clock_out <= 1'b1;
      end else begin
        system_clock_out <= ~system_clock_out;
      end
    end
  end

  // read mux: output bits show the latch, input bits the pin
  always_comb begin
    rd_val = 8'h00;
    if (is_lane_reg(idx)) begin
      if (idx[0]) begin
        rd_val = dir_reg[lane_of(idx)];
      end else begin
        rd_val = (dir_reg[lane_of(idx)] & data_reg[lane_of(idx)])
               | (~dir_reg[lane_of(idx)] & level[lane_of(idx)]);
      end
      if (lane_of(idx) == LANE_P3) begin
        rd_val = rd_val & PORT3_USED;
      end
    end else if (idx == IDX_COLOUR) begin
      rd_val = {1'b0, colour_data_reg, 2'b00};
    end else if (idx == IDX_OSC) begin
      rd_val = {6'h00, osc_level_reg};
    end else if (idx == IDX_ALT) begin
      rd_val = alt_reg;
    end else if (idx == IDX_PWM_EN) begin
      rd_val = pwm_en_reg;
    end else if (idx == IDX_MODE) begin
      rd_val = {6'h00, mode_reg};
    end
  end

  // apb answer: one wait state, data captured as pready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      // refused and misaligned reads return zero rather than a neighbour's data
      prdata <= (pwrite || !addr_ok) ? 32'h0000_0000 : {24'h00_0000, rd_val};
      pslverr <= !(addr_ok && is_mapped(idx));
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("apb access not answered in one cycle");
  a_readback_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && !pready && paddr == ADDR_W'(32'h300)
      && dir_reg[LANE_P0] == 8'hff) |=> prdata[7:0] == $past(data_reg[LANE_P0]))
    else $error("output bit read does not return latch");
  a_addr_low: assert property (@(posedge pclk) disable iff (!presetn)
    bus_mode |=> (gpio_pin_out[LANE_P0] == $past(ext_addr[7:0])
      && gpio_pin_oe_n[LANE_P0] == 8'h00))
    else $error("address low byte not on port_zero");
  a_addr_high: assert property (@(posedge pclk) disable iff (!presetn)
    bus_mode |=> gpio_pin_out[LANE_P1] == $past(ext_addr[15:8]))
    else $error("address high byte not on port_one");
  a_data_release: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_mode && !ext_write) |=> gpio_pin_oe_n[LANE_P2] == 8'hff)
    else $error("data bus driven during read");
  a_rw_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    bus_mode |=> gpio_pin_out[LANE_P3][0] == !$past(ext_write))
    else $error("read/write strobe wrong");
  a_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
    gpio_pin_out[LANE_P3][6:2] == 5'h00 && gpio_pin_out[LANE_P6] == 8'h00)
    else $error("open-drain bit driven high");
  a_clock_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (!halt_reg && !stop_instruction && !wait_instruction)
      |=> system_clock_out != $past(system_clock_out))
    else $error("clock output failed to toggle");
  a_clock_parked: assert property (@(posedge pclk) disable iff (!presetn)
    (stop_instruction || wait_instruction) |=> (system_clock_out && halt_reg))
    else $error("clock output not parked high");
  a_rom_off: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 rom_disable == ($past(mode_reg) == MODE_MICRO))
    else $error("rom disable disagrees with mode");
  c_bus_mode: cover property (@(posedge pclk) disable iff (!presetn)
    !bus_mode ##1 bus_mode);
  c_halt_resume: cover property (@(posedge pclk) disable iff (!presetn)
    halt_reg ##1 !halt_reg);
  c_port_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_fire && idx == IDX_P0_DATA);
endmodule : io_ports
`default_nettype wire

// *** sim/pin_world.sv ***
// far-side model: external devices and pull-ups seen by the port pins
`timescale 1ns/100ps
`default_nettype none
module pin_world
  import gpio_pkg::*;
(
  input wire logic [NUM_LANES-1:0][7:0] pin_out,
  input wire logic [NUM_LANES-1:0][7:0] pin_oe_n,
  input wire logic [NUM_LANES-1:0][7:0] ext_drive,
  output logic [NUM_LANES-1:0][7:0] pin_level
);
  // a released pin shows what the outside world drives, never the stale device value
  always_comb begin
    for (int p = 0; p < NUM_LANES; p++) begin
      for (int b = 0; b < 8; b++) begin
        pin_level[p][b] = pin_oe_n[p][b] ? ext_drive[p][b] : pin_out[p][b];
      end
    end
  end
endmodule : pin_world
`default_nettype wire

// *** sim/io_ports_tb_top.sv ***
// self-checking bench for the i/o port block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module io_ports_tb_top
  import gpio_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, sco, rom_disable, a;
  logic [NUM_LANES-1:0][7:0] pin_in, pin_out, pin_oe_n, ext_drive, lvl;
  logic [15:0] ext_addr = 16'h0000;
  logic stop_pulse = 1'b0, wait_pulse = 1'b0, resume_pulse = 1'b0;
  // same-clock alternate owners and pins driven by the scenarios
  logic [7:0] ext_wdata = 8'h00, pwm_low = 8'h00;
  logic ext_write = 1'b0, ext_sync = 1'b0, pwm_nine = 1'b0, strap = 1'b0;
  logic osc_in = 1'b0, osc_out = 1'b0;
  logic [3:0] ser_one_val = 4'hf, ser_one_drive = 4'h0;
  logic [4:0] colour_in = 5'h00, colour_out;
  logic [1:0] tmr_clk;
  int mismatches = 0, n_compared = 0, cycles = 0;
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  io_ports dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_pin_in(pin_in), .gpio_pin_out(pin_out),
    .gpio_pin_oe_n(pin_oe_n), .gpio_pin_level(lvl), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_write(ext_write), .ext_sync(ext_sync),
    .serial_one_val(ser_one_val), .serial_one_drive(ser_one_drive),
    .serial_two_val(4'hf), .serial_two_drive(4'h0),
    .special_sda_val(1'b1), .special_scl_val(1'b1), .pulse_width_channels_low(pwm_low),
    .pulse_width_channel_eight(1'b0), .pulse_width_channel_nine(pwm_nine),
    .display_colour(colour_in), .colour_output_port(colour_out), .display_osc_in(osc_in),
    .display_osc_out(osc_out), .mode_select_pin(strap), .stop_instruction(stop_pulse),
    .wait_instruction(wait_pulse), .clock_resume(resume_pulse), .system_clock_out(sco),
    .timer_ext_clk(tmr_clk), .rom_disable(rom_disable));
  pin_world world (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_drive(ext_drive),
    .pin_level(pin_in));
  // verdict and end of run
  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // watchdog: a hung handshake ends the run as a failure
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // let register changes reach the pins and pin levels reach the readback path
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask : settle
  // port_zero: outputs drive the latch, inputs float and read the pin
  task automatic t_port_zero();
    apb(1'b1, IDX_P0_DATA, 32'h000000a5);
    apb(1'b1, IDX_P0_DIR, 32'h0000000f);
    settle();
    `CHK("p0 oe_n", 8'hf0, pin_oe_n[LANE_P0])
    `CHK("p0 out", 4'h5, pin_out[LANE_P0][3:0])
    `CHK("p0 level", 8'h35, lvl[LANE_P0])
    apb(1'b0, IDX_P0_DATA, 32'h0);
    `CHK("p0 read", 32'h00000035, rd)
    apb(1'b0, IDX_P0_DIR, 32'h0);
    `CHK("p0 dir", 32'h0000000f, rd)
    apb(1'b1, IDX_P0_DATA, 32'h0000005a);
    settle();
    `CHK("p0 still floats", 8'hf0, pin_oe_n[LANE_P0])
    apb(1'b1, IDX_P0_DIR, 32'h000000ff);
    apb(1'b0, IDX_P0_DATA, 32'h0);
    `CHK("p0 read all out", 32'h0000005a, rd)
    apb(1'b0, 8'hd0, 32'h0);
    `CHK("unmapped err", 1'b1, err)
  endtask : t_port_zero
  // port_three: two push-pull bits, five open-drain bits
  task automatic t_port_three();
    apb(1'b1, IDX_P0_DATA + 8'h06, 32'h00000000);
    apb(1'b1, IDX_P0_DATA + 8'h07, 32'h0000007f);
    settle();
    `CHK("p3 oe_n low", 8'h80, pin_oe_n[LANE_P3])
    apb(1'b1, IDX_P0_DATA + 8'h06, 32'h0000007f);
    settle();
    `CHK("p3 oe_n high", 8'hfc, pin_oe_n[LANE_P3])
    `CHK("p3 out", 8'h03, pin_out[LANE_P3])
  endtask : t_port_three
  // bus modes take ports zero and one, rom follows the mode
  task automatic t_modes();
    apb(1'b0, IDX_MODE, 32'h0);
    `CHK("reset mode", 32'h00000000, rd)
    ext_addr <= 16'h5a3c;
    apb(1'b1, IDX_MODE, 32'h00000001);
    settle();
    `CHK("addr low", 8'h3c, pin_out[LANE_P0])
    `CHK("addr high", 8'h5a, pin_out[LANE_P1])
    `CHK("rom on", 1'b0, rom_disable)
    apb(1'b0, IDX_MODE, 32'h0);
    `CHK("mode read", 32'h00000001, rd)
    ext_wdata <= 8'h96;
    ext_write <= 1'b1;
    ext_sync <= 1'b1;
    settle();
    `CHK("data bus out", 8'h96, pin_out[LANE_P2])
    `CHK("data bus drive", 8'h00, pin_oe_n[LANE_P2])
    `CHK("write strobe", 2'b10, pin_out[LANE_P3][1:0])
    ext_write <= 1'b0;
    ext_sync <= 1'b0;
    apb(1'b1, IDX_MODE, 32'h00000002);
    settle();
    `CHK("rom off", 1'b1, rom_disable)
    apb(1'b1, IDX_MODE, 32'h00000000);
    settle();
    `CHK("latch kept", 4'ha, pin_out[LANE_P0][3:0])
  endtask : t_modes
  // clock output toggles, then parks high after a halt
  task automatic t_clock_out();
    @(posedge pclk);
    a = sco;
    @(posedge pclk);
    `CHK("clk toggles", ~a, sco)
    stop_pulse <= 1'b1;
    @(posedge pclk);
    stop_pulse <= 1'b0;
    repeat (3) @(posedge pclk);
    repeat (4) begin
      @(posedge pclk);
      `CHK("clk parked", 1'b1, sco)
    end
    resume_pulse <= 1'b1;
    @(posedge pclk);
    resume_pulse <= 1'b0;
    @(posedge pclk);
    a = sco;
    @(posedge pclk);
    `CHK("clk resumed", ~a, sco)
    wait_pulse <= 1'b1;
    @(posedge pclk);
    wait_pulse <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("clk parked on wait", 1'b1, sco)
  endtask : t_clock_out
  // alternate owners: serial and pwm on port_four, pwm on port_six, colour, timer, osc
  task automatic t_alt();
    ser_one_val <= 4'h5;
    ser_one_drive <= 4'hf;
    pwm_low <= 8'h0a;
    colour_in <= 5'h15;
    osc_in <= 1'b1;
    apb(1'b1, IDX_ALT, 32'h000000a9);
    apb(1'b1, IDX_PWM_EN, 32'h0000000f);
    settle();
    `CHK("p4 owners", 8'hb5, pin_oe_n[LANE_P4])
    `CHK("pwm nine pulls low", 1'b0, pin_oe_n[LANE_P4][6])
    `CHK("p6 pwm", 8'hfa, pin_oe_n[LANE_P6])
    `CHK("colour pins", 5'h15, colour_out)
    `CHK("timer clocks", 2'b01, tmr_clk)
    apb(1'b0, IDX_OSC, 32'h0);
    `CHK("osc port", 32'h00000001, rd)
  endtask : t_alt
  // a second reset with the strap high forces expansion mode
  task automatic t_strap();
    strap <= 1'b1;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, IDX_MODE, 32'h0);
    `CHK("strap mode", 32'h00000001, rd)
    `CHK("strap addr low", 8'h3c, pin_out[LANE_P0])
  endtask : t_strap
  // main sequence
  initial begin
    ext_drive = {8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h3c};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    t_port_zero();
    t_port_three();
    t_modes();
    t_clock_out();
    t_alt();
    t_strap();
    conclude();
  end
endmodule : io_ports_tb_top
`default_nettype wire
